// file: line_reset_store_align_ctrl_test.sv
// Testbench joining host and device ends over the control port
`timescale 1ns/1ps
`include "lra_defines.svh"
module line_reset_store_align_ctrl_test;
    logic        sys_clk, srst, hsel, hwrite, rxClkStable, txClkStable, rxChanValid;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hready, hresp, lineRestartActive, rxAlignStrobe, txAlignStrobe;
    logic [5:0]  rxPtrSep, txPtrSep;
    logic [4:0]  rxChanNum, rxMonitorSelect;
    logic [7:0]  rxChanData, rxChannelMonitor, b;
    logic [31:0] r;
    int          n_fail, check_count, cycles, restartCycles, i;
    int          alignCnt[2];
    lra_port_if portBus();
    lra_line_dev #(.RESTART_CYCLES(4)) lra_line_dev_inst (
        .sys_clk(sys_clk), .srst(srst), .port(portBus), .rxPtrSep(rxPtrSep), .txPtrSep(txPtrSep),
        .rxChanValid(rxChanValid), .rxChanNum(rxChanNum), .rxChanData(rxChanData),
        .lineRestartActive(lineRestartActive), .rxAlignStrobe(rxAlignStrobe), .txAlignStrobe(txAlignStrobe),
        .rxMonitorSelect(rxMonitorSelect), .rxChannelMonitor(rxChannelMonitor));
    lra_line_host lra_line_host_inst (
        .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .rxClkStable(rxClkStable), .txClkStable(txClkStable), .port(portBus));
    lra_line_monitor #(.RESTART_CYCLES(4)) lra_line_monitor_inst (
        .sys_clk(sys_clk), .srst(srst), .addr(portBus.addr), .wdata(portBus.wdata), .wr(portBus.wr),
        .rxPtrSep(rxPtrSep), .txPtrSep(txPtrSep), .lineRestartActive(lineRestartActive),
        .rxAlignStrobe(rxAlignStrobe), .txAlignStrobe(txAlignStrobe), .rxMonitorSelect(rxMonitorSelect));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Event counters and hang limit
    always @(posedge sys_clk) begin
        cycles++;
        if (lineRestartActive === 1'b1) restartCycles++;
        if (rxAlignStrobe === 1'b1) alignCnt[0]++;
        if (txAlignStrobe === 1'b1) alignCnt[1]++;
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks=%0d failures=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single AHB-Lite transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= `LRA_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        s = 32'h1;
        for (int k = 0; k < 40 && s[0] !== 1'b0; k++) ahb(1'b0, `LRA_AHB_STATUS, 32'h0, s);
        check({31'h0, s[0]}, 32'h0);
    endtask
    task automatic dev_read(input logic [7:0] a, output logic [7:0] q);
        logic [31:0] s;
        ahb(1'b1, `LRA_AHB_READ, {24'h0, a}, s);
        wait_idle();
        ahb(1'b0, `LRA_AHB_STATUS, 32'h0, s);
        q = s[15:8];
    endtask
    initial begin
        srst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = '0;
        rxClkStable = 1'b0; txClkStable = 1'b0; rxPtrSep = '0; txPtrSep = '0;
        rxChanValid = 1'b0; rxChanNum = '0; rxChanData = '0;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        dev_read(8'haa, b);
        check(32'(b), 32'h00);
        ahb(1'b0, 8'h10, 32'h0, r);
        check(r, 32'h0);
        check(32'(hresp), 32'h0);
        dev_read(8'h50, b);
        check(32'(b), 32'h00);
        ahb(1'b1, `LRA_AHB_SEL, 32'h15, r);
        wait_idle();
        dev_read(8'haa, b);
        check(32'(b), 32'h15);
        check(32'(rxMonitorSelect), 32'h15);
        rxChanValid <= 1'b1; rxChanNum <= 5'h14; rxChanData <= 8'h33;
        @(posedge sys_clk);
        rxChanNum <= 5'h15; rxChanData <= 8'ha5;
        @(posedge sys_clk);
        rxChanNum <= 5'h16; rxChanData <= 8'h5a;
        @(posedge sys_clk);
        rxChanValid <= 1'b0;
        dev_read(8'hab, b);
        check(32'(b), 32'ha5);
        check(32'(rxChannelMonitor), 32'ha5);
        ahb(1'b1, `LRA_AHB_CMD, 32'h1, r);
        wait_idle();
        repeat (10) @(posedge sys_clk);
        check(32'(restartCycles), 32'd4);
        ahb(1'b1, `LRA_AHB_CMD, 32'h1, r);
        wait_idle();
        repeat (10) @(posedge sys_clk);
        check(32'(restartCycles), 32'd8);
        for (i = 0; i < 2; i++) begin
            ahb(1'b1, `LRA_AHB_CMD, 32'h2 << i, r);
            wait_idle();
            ahb(1'b0, `LRA_AHB_STATUS, 32'h0, r);
            check({29'h0, r[2:0]}, 32'h2 << i);
            check(32'(alignCnt[i]), 32'd0);
            ahb(1'b1, `LRA_AHB_STATUS, 32'h2 << i, r);
            ahb(1'b0, `LRA_AHB_STATUS, 32'h0, r);
            check({29'h0, r[2:0]}, 32'h0);
            if (i == 0) rxClkStable <= 1'b1;
            else txClkStable <= 1'b1;
            rxPtrSep <= 6'd15;
            txPtrSep <= 6'd15;
            repeat (5) @(posedge sys_clk);
            ahb(1'b1, `LRA_AHB_CMD, 32'h2 << i, r);
            wait_idle();
            repeat (2) @(posedge sys_clk);
            check(32'(alignCnt[i]), 32'd1);
            dev_read(8'hac, b);
            check(32'(b), 32'h08 << i);
            rxPtrSep <= 6'd16;
            txPtrSep <= 6'd16;
            ahb(1'b1, `LRA_AHB_CMD, 32'h2 << i, r);
            wait_idle();
            repeat (2) @(posedge sys_clk);
            check(32'(alignCnt[i]), 32'd1);
            dev_read(8'hac, b);
            check(32'(b), 32'h02 << i);
        end
        finish_test();
    end
endmodule

// file: lra_defines.svh
// Offsets, field positions, reset values and timing counts of the line reset, align and monitor control
`ifndef LRA_DEFINES_SVH
`define LRA_DEFINES_SVH

`define LRA_CTRL_OFFSET      8'haa
`define LRA_MON_OFFSET       8'hab
`define LRA_STAT_OFFSET      8'hac
`define LRA_CTRL_RESET       8'h00
`define LRA_BIT_RESTART      7
`define LRA_BIT_RX_ALIGN     6
`define LRA_BIT_TX_ALIGN     5
`define LRA_SEL_MSB          4
`define LRA_SEL_LSB          0
`define LRA_STAT_BUSY        0
`define LRA_STAT_RX_SKIP     1
`define LRA_STAT_TX_SKIP     2
`define LRA_STAT_RX_DONE     3
`define LRA_STAT_TX_DONE     4
`define LRA_CLK_PERIOD_NS    4
`define LRA_RESTART_NS       1000
`define LRA_RESTART_CYCLES   ((`LRA_RESTART_NS + `LRA_CLK_PERIOD_NS - 1) / `LRA_CLK_PERIOD_NS)
`define LRA_HALF_FRAME       16
`define LRA_PTR_W            6

`define LRA_AHB_SEL          8'h00
`define LRA_AHB_CMD          8'h04
`define LRA_AHB_STATUS       8'h08
`define LRA_AHB_READ         8'h0c
`define LRA_HST_BUSY         0
`define LRA_HST_RX_REFUSED   1
`define LRA_HST_TX_REFUSED   2
`define LRA_HST_DATA_LSB     8
`define LRA_HST_DATA_MSB     15
`define LRA_CMD_RESTART      0
`define LRA_CMD_RX_ALIGN     1
`define LRA_CMD_TX_ALIGN     2
`define LRA_HTRANS_NONSEQ    2'h2

`endif

// file: lra_line_dev.sv
// Device end: line reset, elastic store align and receive channel monitor control register
//
// Overview of operation
// - Rising restart bit starts line-side internal reset
// - Restart repeats only after clear then set
// - Rising rx align bit aligns rx store pointers
// - Rising tx align bit aligns tx store pointers
// - Align ignored when separation already half frame
// - Align executes below half frame, data disrupted
// - Host toggles rx align after rx clock stable
// - Host toggles tx align after tx clock stable
// - Each align needs clear then set again
// - Five select bits pick monitored receive channel
`timescale 1ns/1ps
`include "lra_defines.svh"
module lra_line_dev
    import lra_pkg::*;
#(
    parameter int PTR_W          = `LRA_PTR_W,
    parameter int HALF_FRAME     = `LRA_HALF_FRAME,
    parameter int RESTART_CYCLES = `LRA_RESTART_CYCLES
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    lra_port_if.dev               port,
    input  wire logic [PTR_W-1:0] rxPtrSep,
    input  wire logic [PTR_W-1:0] txPtrSep,
    input  wire logic             rxChanValid,
    input  wire logic [4:0]       rxChanNum,
    input  wire logic [7:0]       rxChanData,
    output logic                  lineRestartActive,
    output logic                  rxAlignStrobe,
    output logic                  txAlignStrobe,
    output logic [4:0]            rxMonitorSelect,
    output logic [7:0]            rxChannelMonitor
);

    localparam logic [PTR_W-1:0] HALF_SEP = PTR_W'(HALF_FRAME);
    localparam int               CNT_W    = $clog2(RESTART_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(RESTART_CYCLES);

    lra_byte_t        ctrl_reg;
    lra_byte_t        monitor_reg;
    lra_byte_t        rdata_reg;
    logic [CNT_W-1:0] restartCnt_reg;
    logic             restartActive_reg;
    logic             rxAlign_reg;
    logic             txAlign_reg;
    logic             rxSkip_reg;
    logic             txSkip_reg;
    logic             rxDone_reg;
    logic             txDone_reg;
    logic             ctrlWrite;
    logic             statRead;
    logic             restartRise;
    logic             rxAlignRise;
    logic             txAlignRise;
    logic             rxAlignNeeded;
    logic             txAlignNeeded;
    lra_byte_t        statusView;
    lra_byte_t        rdata_next;

    assign ctrlWrite = port.wr && (port.addr == `LRA_CTRL_OFFSET);
    assign statRead  = port.rd && (port.addr == `LRA_STAT_OFFSET);

    // Rising edges of written command bits
    assign restartRise = ctrlWrite && port.wdata[`LRA_BIT_RESTART]
                         && !ctrl_reg[`LRA_BIT_RESTART];
    assign rxAlignRise = ctrlWrite && port.wdata[`LRA_BIT_RX_ALIGN]
                         && !ctrl_reg[`LRA_BIT_RX_ALIGN];
    assign txAlignRise = ctrlWrite && port.wdata[`LRA_BIT_TX_ALIGN]
                         && !ctrl_reg[`LRA_BIT_TX_ALIGN];

    assign rxAlignNeeded = rxPtrSep < HALF_SEP;
    assign txAlignNeeded = txPtrSep < HALF_SEP;

    // Control register storage
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_reg <= `LRA_CTRL_RESET;
        end else if (ctrlWrite) begin
            ctrl_reg <= port.wdata;
        end
    end

    // Line-side restart hold counter
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            restartCnt_reg    <= '0;
            restartActive_reg <= 1'b0;
        end else if (restartRise) begin
            restartCnt_reg    <= CNT_LOAD;
            restartActive_reg <= 1'b1;
        end else if (restartCnt_reg > CNT_W'(1)) begin
            restartCnt_reg    <= restartCnt_reg - CNT_W'(1);
        end else begin
            restartCnt_reg    <= '0;
            restartActive_reg <= 1'b0;
        end
    end

    // Receive store align strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxAlign_reg <= 1'b0;
        end else begin
            rxAlign_reg <= rxAlignRise && rxAlignNeeded;
        end
    end

    // Transmit store align strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txAlign_reg <= 1'b0;
        end else begin
            txAlign_reg <= txAlignRise && txAlignNeeded;
        end
    end

    // Sticky align outcome flags, cleared by reading status; a new event wins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxSkip_reg <= 1'b0;
            txSkip_reg <= 1'b0;
            rxDone_reg <= 1'b0;
            txDone_reg <= 1'b0;
        end else begin
            rxSkip_reg <= (rxAlignRise && !rxAlignNeeded) || (rxSkip_reg && !statRead);
            txSkip_reg <= (txAlignRise && !txAlignNeeded) || (txSkip_reg && !statRead);
            rxDone_reg <= (rxAlignRise && rxAlignNeeded) || (rxDone_reg && !statRead);
            txDone_reg <= (txAlignRise && txAlignNeeded) || (txDone_reg && !statRead);
        end
    end

    // Receive channel monitor capture
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            monitor_reg <= '0;
        end else if (rxChanValid
                     && rxChanNum == ctrl_reg[`LRA_SEL_MSB:`LRA_SEL_LSB]) begin
            monitor_reg <= rxChanData;
        end
    end

    // Status view
    always_comb begin
        statusView                   = '0;
        statusView[`LRA_STAT_BUSY]   = restartActive_reg;
        statusView[`LRA_STAT_RX_SKIP] = rxSkip_reg;
        statusView[`LRA_STAT_TX_SKIP] = txSkip_reg;
        statusView[`LRA_STAT_RX_DONE] = rxDone_reg;
        statusView[`LRA_STAT_TX_DONE] = txDone_reg;
    end

    // Read data mux; unmapped addresses read zero
    always_comb begin
        unique case (port.addr)
            `LRA_CTRL_OFFSET: rdata_next = ctrl_reg;
            `LRA_MON_OFFSET:  rdata_next = monitor_reg;
            `LRA_STAT_OFFSET: rdata_next = statusView;
            default:          rdata_next = '0;
        endcase
    end

    // Read data register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_reg <= '0;
        end else if (port.rd) begin
            rdata_reg <= rdata_next;
        end
    end

    // Monitor select copy
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxMonitorSelect  <= '0;
            rxChannelMonitor <= '0;
        end else begin
            rxMonitorSelect  <= ctrl_reg[`LRA_SEL_MSB:`LRA_SEL_LSB];
            rxChannelMonitor <= monitor_reg;
        end
    end

    assign port.rdata        = rdata_reg;
    assign lineRestartActive = restartActive_reg;
    assign rxAlignStrobe     = rxAlign_reg;
    assign txAlignStrobe     = txAlign_reg;

endmodule

// file: lra_line_host.sv
// Host end: AHB-Lite controlled driver of the line reset, align and monitor control port
`timescale 1ns/1ps
`include "lra_defines.svh"
module lra_line_host
    import lra_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        rxClkStable,
    input  wire logic        txClkStable,
    lra_port_if.host         port
);

    lra_host_state_t state_reg;
    lra_byte_t       shadow_reg;
    lra_byte_t       mask_reg;
    lra_byte_t       readData_reg;
    lra_byte_t       portAddr_reg;
    lra_byte_t       portWdata_reg;
    logic            portWr_reg;
    logic            portRd_reg;
    logic            rxRefused_reg;
    logic            txRefused_reg;
    logic [31:0]     hrdata_reg;
    logic            hready_reg;
    logic            dataWr_reg;
    logic [7:0]      dataAddr_reg;
    logic [1:0]      sync1_reg;
    logic [1:0]      sync2_reg;
    logic [1:0]      sync3_reg;
    logic [1:0]      stable_reg;
    logic            addrPhase;
    logic            cmdWrite;
    logic            busy;
    logic [31:0]     statusWord;
    lra_byte_t       reqMask;

    assign addrPhase = hsel && hready && (htrans == `LRA_HTRANS_NONSEQ);
    assign busy      = (state_reg != LRA_IDLE);
    assign cmdWrite  = dataWr_reg && !busy;

    // Clock-present inputs: three stages, change accepted when last two agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= {txClkStable, rxClkStable};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_stable
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                stable_reg[i] <= 1'b0;
            end else if (sync2_reg[i] == sync3_reg[i]) begin
                stable_reg[i] <= sync3_reg[i];
            end
        end
    end

    // Requested command bits, aligns gated by stable backplane clocks
    always_comb begin
        reqMask                     = '0;
        reqMask[`LRA_BIT_RESTART]   = hwdata[`LRA_CMD_RESTART];
        reqMask[`LRA_BIT_RX_ALIGN]  = hwdata[`LRA_CMD_RX_ALIGN] && stable_reg[0];
        reqMask[`LRA_BIT_TX_ALIGN]  = hwdata[`LRA_CMD_TX_ALIGN] && stable_reg[1];
    end

    always_comb begin
        statusWord                                       = '0;
        statusWord[`LRA_HST_BUSY]                        = busy;
        statusWord[`LRA_HST_RX_REFUSED]                  = rxRefused_reg;
        statusWord[`LRA_HST_TX_REFUSED]                  = txRefused_reg;
        statusWord[`LRA_HST_DATA_MSB:`LRA_HST_DATA_LSB]  = readData_reg;
    end

    // AHB address phase capture and zero-wait read data
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dataWr_reg   <= 1'b0;
            dataAddr_reg <= '0;
            hrdata_reg   <= '0;
            hready_reg   <= 1'b0;
        end else begin
            hready_reg   <= 1'b1;
            dataWr_reg   <= addrPhase && hwrite;
            dataAddr_reg <= haddr[7:0];
            if (addrPhase && !hwrite) begin
                hrdata_reg <= (haddr[7:0] == `LRA_AHB_STATUS) ? statusWord : 32'h0;
            end
        end
    end

    // Refused align flags: set wins over write-one-to-clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxRefused_reg <= 1'b0;
            txRefused_reg <= 1'b0;
        end else begin
            rxRefused_reg <= (dataWr_reg && dataAddr_reg == `LRA_AHB_CMD
                              && hwdata[`LRA_CMD_RX_ALIGN] && !stable_reg[0])
                             || (rxRefused_reg && !(dataWr_reg && dataAddr_reg == `LRA_AHB_STATUS
                                                    && hwdata[`LRA_HST_RX_REFUSED]));
            txRefused_reg <= (dataWr_reg && dataAddr_reg == `LRA_AHB_CMD
                              && hwdata[`LRA_CMD_TX_ALIGN] && !stable_reg[1])
                             || (txRefused_reg && !(dataWr_reg && dataAddr_reg == `LRA_AHB_STATUS
                                                    && hwdata[`LRA_HST_TX_REFUSED]));
        end
    end

    // Port sequencer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg     <= LRA_IDLE;
            shadow_reg    <= `LRA_CTRL_RESET;
            mask_reg      <= '0;
            readData_reg  <= '0;
            portAddr_reg  <= '0;
            portWdata_reg <= '0;
            portWr_reg    <= 1'b0;
            portRd_reg    <= 1'b0;
        end else begin
            portWr_reg <= 1'b0;
            portRd_reg <= 1'b0;
            unique case (state_reg)
                LRA_IDLE: begin
                    if (cmdWrite && dataAddr_reg == `LRA_AHB_CMD && reqMask != '0) begin
                        mask_reg      <= reqMask;
                        portAddr_reg  <= `LRA_CTRL_OFFSET;
                        portWdata_reg <= shadow_reg & ~reqMask;
                        portWr_reg    <= 1'b1;
                        shadow_reg    <= shadow_reg & ~reqMask;
                        state_reg     <= LRA_CLEAR;
                    end else if (cmdWrite && dataAddr_reg == `LRA_AHB_SEL) begin
                        portAddr_reg  <= `LRA_CTRL_OFFSET;
                        portWdata_reg <= {shadow_reg[`LRA_BIT_RESTART:`LRA_SEL_MSB+1],
                                          hwdata[`LRA_SEL_MSB:`LRA_SEL_LSB]};
                        portWr_reg    <= 1'b1;
                        shadow_reg    <= {shadow_reg[`LRA_BIT_RESTART:`LRA_SEL_MSB+1],
                                          hwdata[`LRA_SEL_MSB:`LRA_SEL_LSB]};
                        state_reg     <= LRA_WRITE;
                    end else if (cmdWrite && dataAddr_reg == `LRA_AHB_READ) begin
                        portAddr_reg  <= hwdata[7:0];
                        portRd_reg    <= 1'b1;
                        state_reg     <= LRA_READ;
                    end
                end
                LRA_CLEAR: begin
                    portWdata_reg <= shadow_reg | mask_reg;
                    portWr_reg    <= 1'b1;
                    shadow_reg    <= shadow_reg | mask_reg;
                    state_reg     <= LRA_SET;
                end
                LRA_SET: begin
                    state_reg <= LRA_IDLE;
                end
                LRA_WRITE: begin
                    state_reg <= LRA_IDLE;
                end
                LRA_READ: begin
                    state_reg <= LRA_CAPTURE;
                end
                LRA_CAPTURE: begin
                    readData_reg <= port.rdata;
                    state_reg    <= LRA_IDLE;
                end
            endcase
        end
    end

    assign hreadyout  = hready_reg;
    assign hrdata     = hrdata_reg;
    assign hresp      = 1'b0;
    assign port.addr  = portAddr_reg;
    assign port.wdata = portWdata_reg;
    assign port.wr    = portWr_reg;
    assign port.rd    = portRd_reg;

endmodule

// file: lra_line_monitor.sv
// Assertions on the control port and the device outputs
`timescale 1ns/1ps
module lra_line_monitor #(
    parameter int PTR_W          = 6,
    parameter int HALF_FRAME     = 16,
    parameter int RESTART_CYCLES = 4
) (
    input wire logic             sys_clk,
    input wire logic             srst,
    input wire logic [7:0]       addr,
    input wire logic [7:0]       wdata,
    input wire logic             wr,
    input wire logic [PTR_W-1:0] rxPtrSep,
    input wire logic [PTR_W-1:0] txPtrSep,
    input wire logic             lineRestartActive,
    input wire logic             rxAlignStrobe,
    input wire logic             txAlignStrobe,
    input wire logic [4:0]       rxMonitorSelect
);
    logic [7:0] ctrlReg;
    int         restartCnt;
    logic       ctrlWr;
    assign ctrlWr = wr && addr == 8'haa;
    // Shadow of the control register as written over the port
    always_ff @(posedge sys_clk) begin
        if (srst) ctrlReg <= 8'h00;
        else if (ctrlWr) ctrlReg <= wdata;
    end
    // Cycles the restart has been active
    always_ff @(posedge sys_clk) begin
        if (srst) restartCnt <= 0;
        else restartCnt <= lineRestartActive ? restartCnt + 1 : 0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_restart_start: assert property (ctrlWr && wdata[7] && !ctrlReg[7] |=> lineRestartActive)
        else $error("restart did not start after rising write");
    a_restart_cause: assert property ($rose(lineRestartActive) |-> $past(ctrlWr && wdata[7] && !ctrlReg[7]))
        else $error("restart started without rising write");
    a_restart_len: assert property ($fell(lineRestartActive) |-> restartCnt == RESTART_CYCLES)
        else $error("restart length wrong");
    a_restart_bound: assert property (restartCnt <= RESTART_CYCLES)
        else $error("restart too long");
    a_rx_align_go: assert property (ctrlWr && wdata[6] && !ctrlReg[6] && rxPtrSep < HALF_FRAME |=> rxAlignStrobe)
        else $error("rx align not executed");
    a_rx_align_cause: assert property (rxAlignStrobe |-> $past(ctrlWr && wdata[6] && !ctrlReg[6] && rxPtrSep < HALF_FRAME))
        else $error("rx align without cause");
    a_tx_align_go: assert property (ctrlWr && wdata[5] && !ctrlReg[5] && txPtrSep < HALF_FRAME |=> txAlignStrobe)
        else $error("tx align not executed");
    a_tx_align_cause: assert property (txAlignStrobe |-> $past(ctrlWr && wdata[5] && !ctrlReg[5] && txPtrSep < HALF_FRAME))
        else $error("tx align without cause");
    a_select_follow: assert property (rxMonitorSelect == $past(ctrlReg[4:0]))
        else $error("monitor select does not follow control");
endmodule

// file: lra_pkg.sv
// Types of the line reset, align and monitor control: the byte type is shared by both ends, the state type is used by the host only
package lra_pkg;
    typedef logic [7:0] lra_byte_t;
    typedef enum logic [2:0] {
        LRA_IDLE,
        LRA_CLEAR,
        LRA_SET,
        LRA_WRITE,
        LRA_READ,
        LRA_CAPTURE
    } lra_host_state_t;
endpackage

// file: lra_port_if.sv
// Parallel control port between host and device
`timescale 1ns/1ps
interface lra_port_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    modport dev  (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
